// *** core/qr_switch_ctrl.sv ***
// Contract
// - Supply above turn-on stops pre-charge and starts switching with fresh soft-start.
// - Soft-start is 12 ms total in 4 equal timed steps.
// - Peak limit steps up from 0.32 V to 1 V unless limited further.
// - Turn-on comes from zero crossing; turn-off from current against mains sense.
// - Valley pin above overvoltage level during off-time latches off after blanking.
// - Ringing timer is long below ringing level, short above it.
// - After turn-off gate stays low and zero crossings are ignored during ringing.
// - After ringing interval, next zero crossing turns the gate on.
// - No zero crossing within maximum off-time turns the gate on anyway.
// - Scaled sense current above mains sense turns the switch off.
// - Current comparators masked for blanking after turn-on, setting minimum on-time.
// - Gate high beyond maximum on-time is forced low.
// - Sense current above mains-dependent limit after blanking turns gate off.
// - Shorted winding latches off only when it persists past its blanking.
// - Excess valley pin current during on-time lowers the limit nonlinearly.
// - Supply faults or over-temperature reset, hold off, restart with soft-start.
// - Latched off, pre-charge toggles between supply low and high levels.
//
// Purpose: Digital gate timing, soft-start and protection of a quasi-resonant flyback.
// Assumes: All inputs but zc_current_code are comparator results; all are already synchronous to clk.
// Notes:   nrst is the supply lockout reset; a latch-off clears only through it.
`default_nettype none

module qr_switch_ctrl #(
   parameter int MAX_OFF_CYCLES   = qr_ctrl_pkg::MAX_OFF_CYC,
   parameter int MAX_ON_CYCLES    = qr_ctrl_pkg::MAX_ON_CYC,
   parameter int SOFT_STEP_CYCLES = qr_ctrl_pkg::SOFT_STEP_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire qr_ctrl_pkg::supply_s supply,
   input  wire qr_ctrl_pkg::sense_s  sense,
   input  wire logic [7:0]           zc_current_code,
   output logic                      switch_drive_output,
   output logic                      bus_precharge_enable,
   output logic [9:0]                cs_limit_mv,
   output logic [1:0]                soft_step,
   output logic                      latched_off
);

   localparam int CW = qr_ctrl_pkg::CNT_W;

   // Counters must fit, and blanking must end before the forced turn-off.
   generate
      if (MAX_OFF_CYCLES < 2 || MAX_OFF_CYCLES >= (1 << CW) ||
          MAX_ON_CYCLES <= qr_ctrl_pkg::LEB_CYC || MAX_ON_CYCLES >= (1 << CW) ||
          MAX_OFF_CYCLES <= qr_ctrl_pkg::RING_LONG_CYC ||
          SOFT_STEP_CYCLES < 1 || SOFT_STEP_CYCLES >= (1 << CW)) begin : g_bad_params
         $error("qr_switch_ctrl timing parameters out of range");
      end
   endgenerate

   // Soft-start limit level for a step, equal increments from start to final.
   function automatic logic [9:0] soft_level(input logic [1:0] step);
      int span;
      span = int'(qr_ctrl_pkg::LIMIT_FINAL_MV) - int'(qr_ctrl_pkg::LIMIT_START_MV);
      return 10'(int'(qr_ctrl_pkg::LIMIT_START_MV) + (span * int'(step)) / (qr_ctrl_pkg::SOFT_STEPS - 1));
   endfunction

   // Nonlinear foldback offset from the excess valley pin current.
   function automatic logic [9:0] fold_offset(input logic [7:0] code);
      int excess;
      int sq;
      excess = int'(code) - int'(qr_ctrl_pkg::FOLDBACK_CURRENT_THRESHOLD);
      if (excess < 0) begin
         excess = 0;
      end
      sq = (excess * excess) >> qr_ctrl_pkg::FOLD_SHIFT;
      return (sq > int'(qr_ctrl_pkg::LIMIT_FINAL_MV)) ? qr_ctrl_pkg::LIMIT_FINAL_MV : 10'(sq);
   endfunction

   qr_ctrl_pkg::ctrl_state_e state;
   qr_ctrl_pkg::ctrl_state_e next_state;
   logic [CW-1:0]            on_cnt;
   logic [CW-1:0]            next_on_cnt;
   logic [CW-1:0]            off_cnt;
   logic [CW-1:0]            next_off_cnt;
   logic [CW-1:0]            step_cnt;
   logic [CW-1:0]            next_step_cnt;
   logic [1:0]               next_soft_step;
   logic [9:0]               offset;
   logic [9:0]               next_offset;
   logic [9:0]               next_limit;
   logic                     next_precharge;
   logic                     switching;
   logic                     ovp_fire;
   logic                     sw_fire;
   logic                     kill;
   logic                     ring_done;
   logic                     off_done;
   logic                     leb_done;
   logic                     on_done;
   logic                     cmp_off;

   assign switching = (state == qr_ctrl_pkg::ST_RING) || (state == qr_ctrl_pkg::ST_WAIT) ||
                      (state == qr_ctrl_pkg::ST_ON);

   persist_filter #(
      .HOLD (qr_ctrl_pkg::OVP_BLANK_CYC)
   ) u_ovp_blank (
      .clk   (clk),
      .nrst  (nrst),
      .level (sense.over_ovp && switching && (state != qr_ctrl_pkg::ST_ON)),
      .fire  (ovp_fire)
   );

   persist_filter #(
      .HOLD (qr_ctrl_pkg::SW_BLANK_CYC)
   ) u_sw_blank (
      .clk   (clk),
      .nrst  (nrst),
      .level (sense.shorted_winding && (state == qr_ctrl_pkg::ST_ON)),
      .fire  (sw_fire)
   );

   // ringing length select
   // The select level is watched throughout the interval, so a late rise shortens it.
   assign ring_done = sense.ring_above ? (off_cnt >= CW'(qr_ctrl_pkg::RING_SHORT_CYC - 1)) :
                                         (off_cnt >= CW'(qr_ctrl_pkg::RING_LONG_CYC - 1));
   assign off_done  = off_cnt >= CW'(MAX_OFF_CYCLES - 1);
   assign leb_done  = on_cnt >= CW'(qr_ctrl_pkg::LEB_CYC - 1);
   assign on_done   = on_cnt >= CW'(MAX_ON_CYCLES - 1);
   assign cmp_off   = sense.peak_over_mains || sense.over_limit;
   assign kill      = supply.fault || ovp_fire || sw_fire;

   // Next state, counters and pre-charge control.
   always_comb begin
      next_state     = state;
      next_on_cnt    = on_cnt;
      next_off_cnt   = off_cnt;
      next_step_cnt  = step_cnt;
      next_soft_step = soft_step;
      next_offset    = offset;
      next_precharge = bus_precharge_enable;
      case (state)
         qr_ctrl_pkg::ST_PRECHARGE: begin
            next_precharge = 1'b1;
            if (supply.above_on && !supply.fault) begin
               next_state     = qr_ctrl_pkg::ST_RING;
               next_precharge = 1'b0;
               next_off_cnt   = '0;
               next_step_cnt  = '0;
               next_soft_step = 2'h0;
               next_offset    = 10'h000;
            end
         end
         qr_ctrl_pkg::ST_RING: begin
            next_off_cnt = off_cnt + CW'(1);
            if (ring_done) begin
               next_state = qr_ctrl_pkg::ST_WAIT;
            end
         end
         qr_ctrl_pkg::ST_WAIT: begin
            next_off_cnt = off_cnt + CW'(1);
            if (sense.valley_detect_input || off_done) begin
               next_state  = qr_ctrl_pkg::ST_ON;
               next_on_cnt = '0;
            end
         end
         qr_ctrl_pkg::ST_ON: begin
            next_on_cnt = on_cnt + CW'(1);
            next_offset = fold_offset(zc_current_code);
            if ((leb_done && cmp_off) || on_done) begin
               next_state   = qr_ctrl_pkg::ST_RING;
               next_off_cnt = '0;
            end
         end
         qr_ctrl_pkg::ST_LATCHED: begin
            if (supply.low_level) begin
               next_precharge = 1'b1;
            end else if (supply.high_level) begin
               next_precharge = 1'b0;
            end
         end
         default: begin
            next_state     = qr_ctrl_pkg::ST_PRECHARGE;
            next_precharge = 1'b1;
         end
      endcase
      if (switching && soft_step != 2'(qr_ctrl_pkg::SOFT_STEPS - 1)) begin
         if (step_cnt == CW'(SOFT_STEP_CYCLES - 1)) begin
            next_step_cnt  = '0;
            next_soft_step = soft_step + 2'h1;
         end else begin
            next_step_cnt = step_cnt + CW'(1);
         end
      end
      if (switching && (ovp_fire || sw_fire)) begin
         next_state     = qr_ctrl_pkg::ST_LATCHED;
         next_precharge = 1'b0;
      end
      if (switching && supply.fault) begin
         next_state     = qr_ctrl_pkg::ST_PRECHARGE;
         next_precharge = 1'b1;
      end
   end

   // limit is soft level less foldback, floored at zero.
   always_comb begin
      if (next_offset >= soft_level(next_soft_step)) begin
         next_limit = 10'h000;
      end else begin
         next_limit = soft_level(next_soft_step) - next_offset;
      end
   end

   // State and output registers; the gate follows the on state directly.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state                <= qr_ctrl_pkg::ST_PRECHARGE;
         on_cnt               <= '0;
         off_cnt              <= '0;
         step_cnt             <= '0;
         soft_step            <= 2'h0;
         offset               <= 10'h000;
         cs_limit_mv          <= qr_ctrl_pkg::LIMIT_START_MV;
         bus_precharge_enable <= 1'b1;
         switch_drive_output  <= 1'b0;
         latched_off          <= 1'b0;
      end else begin
         state                <= next_state;
         on_cnt               <= next_on_cnt;
         off_cnt              <= next_off_cnt;
         step_cnt             <= next_step_cnt;
         soft_step            <= next_soft_step;
         offset               <= next_offset;
         cs_limit_mv          <= next_limit;
         bus_precharge_enable <= next_precharge;
         switch_drive_output  <= (next_state == qr_ctrl_pkg::ST_ON);
         latched_off          <= (next_state == qr_ctrl_pkg::ST_LATCHED);
      end
   end

   // Checks on gate timing and protection behaviour.
   a_start_handoff: assert property (@(posedge clk) disable iff (!nrst)
      (state == qr_ctrl_pkg::ST_PRECHARGE && supply.above_on && !supply.fault)
      |=> (!bus_precharge_enable && soft_step == 2'h0 && cs_limit_mv == qr_ctrl_pkg::LIMIT_START_MV))
      else $error("start did not stop pre-charge with fresh soft-start");

   a_soft_step_up: assert property (@(posedge clk) disable iff (!nrst)
      ($changed(soft_step) && soft_step != 2'h0) |-> (soft_step == $past(soft_step) + 2'h1))
      else $error("soft-start step skipped");

   a_ring_hold: assert property (@(posedge clk) disable iff (!nrst)
      $fell(switch_drive_output) |-> !switch_drive_output [*8])
      else $error("gate rose during ringing suppression");

   a_turn_on_src: assert property (@(posedge clk) disable iff (!nrst)
      (state == qr_ctrl_pkg::ST_WAIT && sense.valley_detect_input && !kill) |=> switch_drive_output)
      else $error("zero crossing after ringing did not turn gate on");

   a_max_off: assert property (@(posedge clk) disable iff (!nrst)
      (state == qr_ctrl_pkg::ST_WAIT && off_cnt == CW'(MAX_OFF_CYCLES - 1) && !kill) |=> switch_drive_output)
      else $error("maximum off-time did not force turn-on");

   // Inside blanking only a fault or a latch-off may end the on-time, never a comparator.
   a_leb_mask: assert property (@(posedge clk) disable iff (!nrst)
      (state == qr_ctrl_pkg::ST_ON && !leb_done && !kill) |=> switch_drive_output)
      else $error("gate fell inside blanking");

   // A supply fault or a protection latch-off may legally cut the on-time short.
   a_min_on: assert property (@(posedge clk) disable iff (!nrst)
      $fell(switch_drive_output) |-> ($past(on_cnt) >= CW'(qr_ctrl_pkg::LEB_CYC - 1) || $past(kill)))
      else $error("on-time shorter than blanking");

   a_cmp_off: assert property (@(posedge clk) disable iff (!nrst)
      (state == qr_ctrl_pkg::ST_ON && leb_done && cmp_off) |=> !switch_drive_output)
      else $error("comparator did not turn gate off");

   a_max_on: assert property (@(posedge clk) disable iff (!nrst)
      (state == qr_ctrl_pkg::ST_ON && on_cnt == CW'(MAX_ON_CYCLES - 1)) |=> !switch_drive_output)
      else $error("maximum on-time did not force turn-off");

   a_latch_hold: assert property (@(posedge clk) disable iff (!nrst)
      latched_off |=> (latched_off && !switch_drive_output))
      else $error("latch-off released without reset");

   a_fault_restart: assert property (@(posedge clk) disable iff (!nrst)
      (supply.fault && switching) |=> (state == qr_ctrl_pkg::ST_PRECHARGE && !switch_drive_output))
      else $error("supply fault did not restart");

   a_latch_charge: assert property (@(posedge clk) disable iff (!nrst)
      (state == qr_ctrl_pkg::ST_LATCHED && supply.low_level) |=> bus_precharge_enable)
      else $error("latched pre-charge did not turn on at low level");

endmodule

`default_nettype wire

// *** include/qr_ctrl_pkg.sv ***
// Purpose: Shared constants, timing counts and carrier types of the quasi-resonant switch controller.
// Assumes: A 250 MHz core clock; analog levels arrive as comparator results, the valley pin current as an 8-bit code.
// Notes:   Times are kept in ns; each cycle count is derived from its time and the clock period.
`default_nettype none

package qr_ctrl_pkg;

   // Core clock period in ns.
   localparam int CLK_PERIOD_NS = 4;

   // Least time rounded up to whole cycles, never below one.
   function automatic int least_cycles(input int t_ns);
      int c;
      c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Longest time rounded down to whole cycles, never below one.
   function automatic int most_cycles(input int t_ns);
      int c;
      c = t_ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Width of the on-time and off-time counters.
   localparam int CNT_W = 24;

   // Timing figures in ns.
   localparam int LEADING_EDGE_BLANK_INTERVAL_NS    = 300;
   localparam int RING_LONG_NS                      = 2500;
   localparam int RING_SHORT_NS                     = 1000;
   localparam int MAX_OFF_INTERVAL_NS               = 50000;
   localparam int MAX_ON_INTERVAL_NS                = 25000;
   localparam int OVP_BLANK_NS                      = 1000;
   localparam int SHORTED_WINDING_BLANK_INTERVAL_NS = 200;
   localparam int SOFT_TOTAL_NS                     = 12000000;
   localparam int SOFT_STEPS                        = 4;

   // Derived cycle counts.
   localparam int LEB_CYC        = least_cycles(LEADING_EDGE_BLANK_INTERVAL_NS);
   localparam int RING_LONG_CYC  = least_cycles(RING_LONG_NS);
   localparam int RING_SHORT_CYC = least_cycles(RING_SHORT_NS);
   localparam int MAX_OFF_CYC    = most_cycles(MAX_OFF_INTERVAL_NS);
   localparam int MAX_ON_CYC     = most_cycles(MAX_ON_INTERVAL_NS);
   localparam int OVP_BLANK_CYC  = least_cycles(OVP_BLANK_NS);
   localparam int SW_BLANK_CYC   = least_cycles(SHORTED_WINDING_BLANK_INTERVAL_NS);
   localparam int SOFT_STEP_CYC  = least_cycles(SOFT_TOTAL_NS / SOFT_STEPS);

   // Peak-current limit levels in mV on the sense pin.
   localparam logic [9:0] LIMIT_START_MV = 10'h140;
   localparam logic [9:0] LIMIT_FINAL_MV = 10'h3E8;

   // Foldback: valley pin current code above which the limit is reduced.
   localparam logic [7:0] FOLDBACK_CURRENT_THRESHOLD = 8'h10;
   localparam int         FOLD_SHIFT                 = 4;

   // Supply comparator results.
   typedef struct packed {
      logic above_on;    // Supply above turn-on level.
      logic fault;       // Undervoltage, overvoltage or over-temperature.
      logic low_level;   // Supply at or below the latched recharge low level.
      logic high_level;  // Supply at or above the latched recharge high level.
   } supply_s;

   // Sensing front-end comparator results.
   typedef struct packed {
      logic valley_detect_input; // Zero crossing seen on the valley pin.
      logic over_ovp;            // Valley pin above output overvoltage level.
      logic ring_above;          // Valley pin above ringing select level.
      logic peak_over_mains;     // Scaled sense current above mains sense input.
      logic over_limit;          // Sense current above the current limit.
      logic shorted_winding;     // Sense current above shorted winding level.
   } sense_s;

   // Controller states.
   typedef enum logic [2:0] {
      ST_PRECHARGE,
      ST_RING,
      ST_WAIT,
      ST_ON,
      ST_LATCHED
   } ctrl_state_e;

endpackage

`default_nettype wire

// *** core/persist_filter.sv ***
// Purpose: Fires once a comparator level has held for a set number of cycles.
// Assumes: Input is synchronous to clk.
// Notes:   Any gap in the level restarts the count, so short spikes never fire.
`default_nettype none

module persist_filter #(
   parameter int HOLD = 4
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic level,
   output logic      fire
);

   localparam int W = $clog2(HOLD + 1);

   generate
      if (HOLD < 1) begin : g_bad_hold
         $error("persist_filter needs HOLD of one or more");
      end
   endgenerate

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   // Count while the level holds, saturate at the hold length.
   always_comb begin
      if (!level) begin
         next_cnt = '0;
      end else if (cnt == W'(HOLD)) begin
         next_cnt = cnt;
      end else begin
         next_cnt = cnt + W'(1);
      end
   end

   // Counter register.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // Fire only with the level still present.
   assign fire = level && (cnt == W'(HOLD));

endmodule

`default_nettype wire

// *** verification/switch_sense_model.sv ***
// Purpose: Behavioural power switch and sensing front end facing the switch controller.
// Assumes: Sensed current ramps 4 mV per cycle while the gate is high.
// Notes:   Valley, ring and overvoltage levels show only while the switch is off.
`default_nettype none

module switch_sense_model (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 gate,
   input  wire logic [9:0]           cs_limit_mv,
   input  wire logic                 valley_en,
   input  wire logic                 ring_hi,
   input  wire logic                 ovp,
   input  wire logic                 sw,
   input  wire logic [15:0]          trip_cyc,
   output var  qr_ctrl_pkg::sense_s  sense
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] on_cnt;

   // The primary current restarts from zero at every turn-on.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) on_cnt <= '0;
      else on_cnt <= gate ? on_cnt + 16'h1 : '0;
   end

   // Comparators only see the current while the switch conducts.
   // scaled mains trip
   always_comb begin
      sense = '0;
      sense.peak_over_mains     = gate && (on_cnt >= trip_cyc);
      sense.over_limit          = gate && ({on_cnt, 2'h0} > {8'h00, cs_limit_mv});
      sense.shorted_winding     = gate && sw;
      sense.valley_detect_input = !gate && valley_en;
      sense.ring_above          = !gate && ring_hi;
      sense.over_ovp            = !gate && ovp;
   end

endmodule

`default_nettype wire

// *** verification/tb_qr_switch_ctrl.sv ***
// Purpose: Self-checking bench of the quasi-resonant switch controller.
// Assumes: Short counts: max off 700, max on 200, soft step 20 cycles.
// Notes:   Timings are judged in small windows since the gate answers one cycle late.
`default_nettype none

module tb_qr_switch_ctrl;
   timeunit 1ns;
   timeprecision 1ps;

   logic                 clk         = 1'b0;
   logic                 nrst        = 1'b0;
   qr_ctrl_pkg::supply_s supply      = '0;
   qr_ctrl_pkg::sense_s  sense;
   logic [7:0]           zc_code     = 8'h00;
   logic                 valley_en   = 1'b0;
   logic                 ring_hi     = 1'b0;
   logic                 ovp         = 1'b0;
   logic                 sw          = 1'b0;
   logic [15:0]          trip_cyc    = 16'hFFFF;
   logic                 switch_drive_output;
   logic                 bus_precharge_enable;
   logic [9:0]           cs_limit_mv;
   logic [1:0]           soft_step;
   logic                 latched_off;
   logic [9:0]           lvl [4]     = '{10'h140, 10'h222, 10'h305, 10'h3E8};
   int                   err_total   = 0;
   int                   num_checks  = 0;

   always #2 clk = ~clk;

   qr_switch_ctrl #(
      .MAX_OFF_CYCLES  (700),
      .MAX_ON_CYCLES   (200),
      .SOFT_STEP_CYCLES(20)
   ) qr_switch_ctrl_inst (
      .clk                 (clk),
      .nrst                (nrst),
      .supply              (supply),
      .sense               (sense),
      .zc_current_code     (zc_code),
      .switch_drive_output (switch_drive_output),
      .bus_precharge_enable(bus_precharge_enable),
      .cs_limit_mv         (cs_limit_mv),
      .soft_step           (soft_step),
      .latched_off         (latched_off)
   );

   switch_sense_model switch_sense_model_inst (
      .clk        (clk),
      .nrst       (nrst),
      .gate       (switch_drive_output),
      .cs_limit_mv(cs_limit_mv),
      .valley_en  (valley_en),
      .ring_hi    (ring_hi),
      .ovp        (ovp),
      .sw         (sw),
      .trip_cyc   (trip_cyc),
      .sense      (sense)
   );

   // Inputs always move 1 ns after the edge so no race with the design.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic rng(input string name, input int lo, input int hi, input int got);
      num_checks++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask

   // Bounded waits; a hang shows up as a count out of its window.
   task automatic wait_gate(input logic v, output int n);
      n = 0;
      while (switch_drive_output !== v && n < 2000) begin
         step(1);
         n++;
      end
   endtask

   task automatic wait_latch(output int n);
      n = 0;
      while (latched_off !== 1'b1 && n < 1000) begin
         step(1);
         n++;
      end
   endtask

   task automatic do_reset();
      nrst = 1'b0;
      supply = '0;
      step(6);
      nrst = 1'b1;
      step(1);
      chk("gate", 1'b0, switch_drive_output);
      chk("precharge", 1'b1, bus_precharge_enable);
      chk("limit", 10'h140, cs_limit_mv);
      chk("step", 2'h0, soft_step);
      chk("latched", 1'b0, latched_off);
   endtask

   task automatic start_up();
      supply.above_on = 1'b1;
      step(1);
      chk("precharge", 1'b0, bus_precharge_enable);
      chk("step", 2'h0, soft_step);
   endtask

   task automatic t_soft_ring();
      int bad;
      int n1;
      int n;
      bad = 0;
      n1 = 0;
      valley_en = 1'b1;
      start_up();
      for (int i = 0; i < 100; i++) begin
         if (cs_limit_mv !== lvl[soft_step]) bad++;
         if (soft_step === 2'h1) n1++;
         step(1);
      end
      chk("soft levels", 0, bad);
      chk("step span", 20, n1);
      chk("last step", 2'h3, soft_step);
      wait_gate(1'b1, n);
      rng("long ring", 524, 528, n);
      ring_hi = 1'b1;
      wait_gate(1'b0, n);
      rng("max on", 199, 201, n);
      wait_gate(1'b1, n);
      rng("short ring", 250, 252, n);
   endtask

   task automatic t_trip();
      int n;
      trip_cyc = 16'h000A;
      wait_gate(1'b0, n);
      rng("blank on", 74, 77, n);
      wait_gate(1'b1, n);
      rng("valley on", 250, 252, n);
      trip_cyc = 16'h0078;
      wait_gate(1'b0, n);
      rng("mains trip", 119, 124, n);
      trip_cyc = 16'hFFFF;
      zc_code = 8'h60;
      wait_gate(1'b1, n);
      wait_gate(1'b0, n);
      chk("fold limit", 10'h258, cs_limit_mv);
      wait_gate(1'b1, n);
      wait_gate(1'b0, n);
      rng("limit trip", 149, 155, n);
      zc_code = 8'h00;
   endtask

   task automatic t_max_off();
      int n;
      valley_en = 1'b0;
      wait_gate(1'b1, n);
      rng("max off", 699, 702, n);
   endtask

   task automatic t_ovp();
      int n;
      wait_gate(1'b0, n);
      ovp = 1'b1;
      step(100);
      ovp = 1'b0;
      chk("ovp spike", 1'b0, latched_off);
      wait_gate(1'b1, n);
      wait_gate(1'b0, n);
      ovp = 1'b1;
      wait_latch(n);
      rng("ovp blank", 250, 253, n);
      chk("latched gate", 1'b0, switch_drive_output);
      ovp = 1'b0;
      supply.low_level = 1'b1;
      step(2);
      chk("recharge on", 1'b1, bus_precharge_enable);
      supply.low_level = 1'b0;
      supply.high_level = 1'b1;
      step(2);
      chk("recharge off", 1'b0, bus_precharge_enable);
   endtask

   task automatic t_fault();
      int n;
      do_reset();
      start_up();
      valley_en = 1'b1;
      wait_gate(1'b1, n);
      supply.fault = 1'b1;
      step(1);
      chk("fault gate", 1'b0, switch_drive_output);
      chk("fault precharge", 1'b1, bus_precharge_enable);
      supply.fault = 1'b0;
      step(2);
      chk("restart", 1'b0, bus_precharge_enable);
      chk("restart step", 2'h0, soft_step);
   endtask

   task automatic t_short();
      int n;
      wait_gate(1'b1, n);
      sw = 1'b1;
      step(30);
      sw = 1'b0;
      wait_gate(1'b0, n);
      chk("sw spike", 1'b0, latched_off);
      wait_gate(1'b1, n);
      sw = 1'b1;
      wait_latch(n);
      rng("sw blank", 49, 53, n);
      chk("sw gate", 1'b0, switch_drive_output);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // The whole run needs some 6000 cycles, so 50000 cycles means a hang.
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end

   initial begin
      do_reset();
      t_soft_ring();
      t_trip();
      t_max_off();
      t_ovp();
      t_fault();
      t_short();
      tally_and_finish();
   end

endmodule

`default_nettype wire
